// file: rtl/clr_dec_pkg.sv
// Package with opcodes, field positions and widths for the clear and decrement-skip execution block
package clr_dec_pkg;
   localparam int          InstrWidth    = 14;
   localparam int          DataWidth     = 8;
   localparam int          AddrWidth     = 7;
   // Opcode prefixes, compared against the top bits of the instruction word
   localparam int          ClrPrefixMsb  = 13;
   localparam int          ClrPrefixLsb  = 7;
   localparam logic [6:0]  ClrPrefix     = 7'h02;   // 00 0001 0
   localparam int          DecPrefixMsb  = 13;
   localparam int          DecPrefixLsb  = 8;
   localparam logic [5:0]  DecPrefix     = 6'h0B;   // 00 1011
   localparam int          DestBit       = 7;
   localparam int          AddrMsb       = 6;
   localparam int          AddrLsb       = 0;
   localparam logic [7:0]  ZeroData      = 8'h00;
   localparam logic [7:0]  OneData       = 8'h01;
   localparam logic [6:0]  ZeroAddr      = 7'h00;

   // Execution states of the block
   typedef enum logic [1:0] {
      StExec = 2'b01,
      StNop  = 2'b10
   } exec_state_t;
endpackage

// file: rtl/regfile_if.sv
// Interface carrying register-file read and write signals between the core modules
`timescale 1ns/1ps
interface regfile_if;
   logic [6:0] rdAddr;
   logic [7:0] rdData;
   logic       wrEn;
   logic [6:0] wrAddr;
   logic [7:0] wrData;
   modport exec (output rdAddr, input rdData, output wrEn, output wrAddr, output wrData);
   modport decode (input rdAddr, output rdData, input wrEn, input wrAddr, input wrData);
endinterface

// file: rtl/instr_decode.sv
// Combinational opcode decoder for the two supported instructions
`timescale 1ns/1ps
module instr_decode (
   input  wire logic [13:0] instr,
   output logic             isClear,
   output logic             isDecSkip,
   output logic             destFile,
   output logic [6:0]       fileAddr
);
   // Pure decode of prefix fields; all other opcodes fall through as inactive
   always_comb begin
      isClear   = instr[clr_dec_pkg::ClrPrefixMsb:clr_dec_pkg::ClrPrefixLsb] == clr_dec_pkg::ClrPrefix;
      isDecSkip = instr[clr_dec_pkg::DecPrefixMsb:clr_dec_pkg::DecPrefixLsb] == clr_dec_pkg::DecPrefix;
      destFile  = instr[clr_dec_pkg::DestBit];
      fileAddr  = instr[clr_dec_pkg::AddrMsb:clr_dec_pkg::AddrLsb];
   end
endmodule // instr_decode

// file: rtl/clear_and_decrement_skip_exec.sv
// Execution logic for clear-working-register and decrement-skip-if-zero
// Timing, one instruction cycle per clock edge:
//   edge N    a word is taken when valid and the block is not in its no-op slot
//   after N   working register, zero strobe, write strobe and discard strobe carry its result
//   after N+1 the strobes drop again; the working register holds until it is written
// A taken skip puts the block in the no-op slot for the following edge. The word offered
// there is the one already fetched: it is ignored here, and the discard strobe tells the
// fetch side to drop it. Busy and the no-op flag are high for exactly that slot.
// The file read is combinational: the address is the low field of the word, and the data
// must come back within the same cycle, because the decrement and the zero test use it
// before the edge that takes the word.
// The file write is registered and lands one cycle after the word is taken. A word right
// behind it that reads the same register sees the old byte; the core must not rely on a
// same-register forward through this block.
// The zero flag is driven only by a set strobe; the decrement never touches any flag, so
// a zero result is reported only through the skip.
// Other opcodes, clear-watchdog included, pass through with no effect here.
// Reset clears everything at once when the pin falls and leaves through two flip-flops,
// so the first word may be offered at the third edge after the pin rises.
// The status input is carried for compatibility and never read by the logic.
// Decoding is duplicated nowhere: the decode module alone looks at the opcode fields.
//
`timescale 1ns/1ps
module clear_and_decrement_skip_exec (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        instrValid,
   input  wire logic [13:0] instr,
   input  wire logic [7:0]  fileRdData,
   input  wire logic [7:0]  statusZeroIn,
   output logic [6:0]       fileRdAddr,
   output logic             fileWrEn,
   output logic [6:0]       fileWrAddr,
   output logic [7:0]       fileWrData,
   output logic [7:0]       workReg,
   output logic             zeroFlagSet,
   output logic             discardFetch,
   output logic             execNop,
   output logic             busy
);
   logic                      rstSync1Q;
   logic                      rstSync2Q;
   logic                      isClear;
   logic                      isDecSkip;
   logic                      destFile;
   logic [6:0]                fileAddr;
   logic [7:0]                decResult;
   logic                      execValid;
   clr_dec_pkg::exec_state_t  state_q;
   logic [7:0]                workReg_q;
   logic                      zeroSet_q;
   logic                      wrEn_q;
   logic [6:0]                wrAddr_q;
   logic [7:0]                wrData_q;
   logic                      discard_q;

   // Carrier for the register-file port: read and write signals travel together
   regfile_if rf ();

   // Reset release synchroniser; assertion stays asynchronous
   // Only the first flop can go metastable on a release close to an edge
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rstSync1Q <= 1'b0;
         rstSync2Q <= 1'b0;
      end else begin
         rstSync1Q <= 1'b1;
         rstSync2Q <= rstSync1Q;
      end
   end

   // Opcode decode, purely combinational; other opcodes leave every strobe low
   instr_decode u_decode (
      .instr     (instr),
      .isClear   (isClear),
      .isDecSkip (isDecSkip),
      .destFile  (destFile),
      .fileAddr  (fileAddr)
   );

   // Read port addressed straight from the instruction word; the file answers in the same cycle
   assign rf.rdAddr  = fileAddr;
   assign rf.rdData  = fileRdData;
   assign fileRdAddr = rf.rdAddr;

   // One less than the operand; wraps from zero to all ones and raises no flag
   function automatic logic [7:0] dec_by_one(input logic [7:0] value);
      dec_by_one = value - clr_dec_pkg::OneData;
   endfunction

   // Zero test for a data byte
   function automatic logic is_zero(input logic [7:0] value);
      is_zero = value == clr_dec_pkg::ZeroData;
   endfunction

   // Qualified strobes for the two instructions and the skip decision
   logic                      clrTake;
   logic                      decTake;
   logic                      skipTake;

   assign decResult = dec_by_one(rf.rdData);
   // Slot after a taken skip is a no-op
   assign execValid = instrValid && (state_q == clr_dec_pkg::StExec);
   // A word offered during the no-op slot never reaches these strobes
   assign clrTake   = execValid && isClear;
   assign decTake   = execValid && isDecSkip;
   assign skipTake  = decTake && is_zero(decResult);

   // Sequencing: a taken skip costs one extra no-op cycle
   always_ff @(posedge clk or negedge rstSync2Q) begin
      if (!rstSync2Q) begin
         state_q <= clr_dec_pkg::StExec;
      end else begin
         unique case (state_q)
            clr_dec_pkg::StExec: begin
               if (skipTake) begin
                  state_q <= clr_dec_pkg::StNop;
               end else begin
                  // No skip: the next word executes normally
                  state_q <= clr_dec_pkg::StExec;
               end
            end
            clr_dec_pkg::StNop: begin
               state_q <= clr_dec_pkg::StExec;
            end
            default: begin
               // Illegal code: recover instead of locking the core
               state_q <= clr_dec_pkg::StExec;
            end
         endcase
      end
   end

   // Discard strobe for the fetch pipeline, one cycle wide
   always_ff @(posedge clk or negedge rstSync2Q) begin
      if (!rstSync2Q) begin
         discard_q <= 1'b0;
      end else begin
         // Drop prefetched word
         // Only a zero result from a taken decrement raises it
         discard_q <= skipTake;
      end
   end

   // Working register; only clear and decrement-to-working touch it
   always_ff @(posedge clk or negedge rstSync2Q) begin
      if (!rstSync2Q) begin
         // Working register reads zero out of reset
         workReg_q <= clr_dec_pkg::ZeroData;
      end else if (clrTake) begin
         workReg_q <= clr_dec_pkg::ZeroData;
      end else if (decTake && !destFile) begin
         workReg_q <= decResult;
      end
   end

   // Zero-flag set strobe; the status logic owns the flag itself
   always_ff @(posedge clk or negedge rstSync2Q) begin
      if (!rstSync2Q) begin
         zeroSet_q <= 1'b0;
      end else begin
         zeroSet_q <= clrTake;
      end
   end

   // File write strobe; registered, so the write lands one cycle after execute
   always_ff @(posedge clk or negedge rstSync2Q) begin
      if (!rstSync2Q) begin
         // No write pending out of reset
         wrEn_q <= 1'b0;
      end else begin
         wrEn_q <= decTake && destFile;
      end
   end

   // Write address and data, held between writes to keep the file port quiet
   always_ff @(posedge clk or negedge rstSync2Q) begin
      if (!rstSync2Q) begin
         wrAddr_q <= clr_dec_pkg::ZeroAddr;
         wrData_q <= clr_dec_pkg::ZeroData;
      end else if (decTake && destFile) begin
         wrAddr_q <= fileAddr;
         wrData_q <= decResult;
      end
   end

   // Register-file write port through the carrier, then out to the pins
   assign rf.wrEn    = wrEn_q;
   assign rf.wrAddr  = wrAddr_q;
   assign rf.wrData  = wrData_q;
   assign fileWrEn   = rf.wrEn;
   assign fileWrAddr = rf.wrAddr;
   assign fileWrData = rf.wrData;

   // Result and strobe outputs, all straight from flip-flops
   assign workReg      = workReg_q;
   assign zeroFlagSet  = zeroSet_q;
   assign discardFetch = discard_q;
   // No-op slot flags; busy tells the fetch side its word is not taken
   assign execNop      = state_q == clr_dec_pkg::StNop;
   assign busy         = state_q == clr_dec_pkg::StNop;

   // Status input is accepted for port compatibility only; this block never alters it
   logic unusedStatus;
   assign unusedStatus = ^statusZeroIn;
endmodule // clear_and_decrement_skip_exec

// file: sim/clear_and_decrement_skip_exec_props.sv
// Checker for the clear and decrement-skip execution block
`timescale 1ns/1ps
module clr_dec_props (
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic        instrValid,
   input wire logic [13:0] instr,
   input wire logic [7:0]  fileRdData,
   input wire logic [6:0]  fileRdAddr,
   input wire logic        fileWrEn,
   input wire logic [6:0]  fileWrAddr,
   input wire logic [7:0]  fileWrData,
   input wire logic [7:0]  workReg,
   input wire logic        zeroFlagSet,
   input wire logic        discardFetch,
   input wire logic        execNop,
   input wire logic        busy
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Taken words only; the no-op cycle swallows its word
   sequence clrTake; instrValid && !busy && instr[13:7] == clr_dec_pkg::ClrPrefix; endsequence
   sequence decTake; instrValid && !busy && instr[13:8] == clr_dec_pkg::DecPrefix; endsequence
   clr_zero_a: assert property (clrTake |=> workReg == 8'h00 && zeroFlagSet) else $error("clear");
   dec_work_a: assert property (decTake ##0 !instr[7] |=> workReg == $past(fileRdData) - 8'h01 && !fileWrEn)
      else $error("dec to working");
   rd_addr_a: assert property (instrValid |-> fileRdAddr == instr[6:0]) else $error("read address");
   dec_file_a: assert property (decTake ##0 instr[7] |=> fileWrEn && fileWrAddr == $past(instr[6:0])
      && fileWrData == $past(fileRdData) - 8'h01 && $stable(workReg)) else $error("dec to file");
   skip_zero_a: assert property (decTake |=> discardFetch == ($past(fileRdData) == 8'h01)) else $error("skip");
   two_cycle_a: assert property (execNop |-> discardFetch ##1 !execNop) else $error("nop length");
   skip_nop_a: assert property (discardFetch |-> execNop && busy) else $error("no nop");
   flags_kept_a: assert property (decTake |=> !zeroFlagSet) else $error("dec set zero");
endmodule // clr_dec_props

bind clear_and_decrement_skip_exec clr_dec_props chk (.clk(clk), .rst_b(rst_b), .instrValid(instrValid),
   .instr(instr), .fileRdData(fileRdData), .fileRdAddr(fileRdAddr), .fileWrEn(fileWrEn), .fileWrAddr(fileWrAddr),
   .fileWrData(fileWrData),
   .workReg(workReg), .zeroFlagSet(zeroFlagSet), .discardFetch(discardFetch), .execNop(execNop), .busy(busy));

// file: sim/tb_clear_and_decrement_skip_exec.sv
// Self-checking bench for the clear and decrement-skip execution block
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin failures++; $display("mismatch %0t got %h", $time, a); end end
module tb_clear_and_decrement_skip_exec;
   logic        clk, rst_b, instrValid, fileWrEn, zeroFlagSet, discardFetch, execNop, busy, t, sh;
   logic [13:0] instr;
   logic [7:0]  fileRdData, fileWrData, workReg, w;
   logic [6:0]  fileRdAddr, fileWrAddr;
   logic [31:0] r = 32'hB0D2B845;
   logic [34:0] q[$];
   logic [34:0] got;
   int          failures, n_compared, cyc;
   clear_and_decrement_skip_exec dut (.clk(clk), .rst_b(rst_b), .instrValid(instrValid), .instr(instr),
      .fileRdData(fileRdData), .statusZeroIn(8'h00), .fileRdAddr(fileRdAddr), .fileWrEn(fileWrEn),
      .fileWrAddr(fileWrAddr), .fileWrData(fileWrData), .workReg(workReg), .zeroFlagSet(zeroFlagSet),
      .discardFetch(discardFetch), .execNop(execNop), .busy(busy));
   // Free-running 25 MHz clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   function automatic logic [31:0] nx(logic [31:0] s); return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]}; endfunction
   task automatic close_out;
      if (failures == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Drive one word at the falling edge and note what it should produce
   task automatic step(logic [13:0] i, logic [7:0] d);
      @(negedge clk);
      instr = i;
      fileRdData = d;
      instrValid = 1'b1;
      if (sh) begin
         sh = 1'b0;
      end
      else if (i[13:7] == clr_dec_pkg::ClrPrefix) begin
         w = 8'h00;
         q.push_back({i[6:0], 16'h0000, w, 4'b1000});
      end
      else if (i[13:8] == clr_dec_pkg::DecPrefix) begin
         sh = d == 8'h01;
         if (!i[7]) w = d - 8'h01;
         q.push_back({i[6:0], i[7], i[7] ? {i[6:0], d - 8'h01} : 15'h0, w, 1'b0, sh, sh, sh});
      end else begin
         // Other opcodes change nothing
         q.push_back({i[6:0], 16'h0000, w, 4'b0000});
      end
   endtask
   // Compare one settled result after each taking edge
   always @(posedge clk) begin
      t = instrValid && !busy && rst_b;
      #1;
      got = {fileRdAddr, fileWrEn, fileWrEn ? {fileWrAddr, fileWrData} : 15'h0, workReg, zeroFlagSet,
         discardFetch, execNop, busy};
      if (t && q.size() > 0) `CHK(got, q.pop_front())
   end
   // Hang guard, well above the few hundred cycles the run needs
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         failures++;
         close_out;
      end
   end
   initial begin
      rst_b = 1'b0;
      instrValid = 1'b0;
      instr = 14'h0000;
      fileRdData = 8'h00;
      w = 8'h00;
      sh = 1'b0;
      repeat (3) @(negedge clk);
      rst_b = 1'b1;
      repeat (2) @(negedge clk);
      // Back-to-back, skip with clear in shadow, wrap, clear without valid, refused word
      step(14'h0B05, 8'h10);
      step(14'h0B85, 8'h01);
      step(14'h0100, 8'h33);
      step(14'h0B00, 8'h00);
      @(negedge clk);
      instrValid = 1'b0;
      instr = 14'h0100;
      step(14'h0064, 8'h01);
      step(14'h0100, 8'h01);
      step(14'h0B7F, 8'h01);
      step(14'h2800, 8'h01);
      repeat (300) begin
         r = nx(r);
         step(r[1:0] == 2'b00 ? {7'h02, r[8:2]} : r[1:0] == 2'b11 ? {6'h0A, r[9:2]} : {6'h0B, r[9:2]},
            r[12] ? 8'h01 : r[20:13]);
      end
      @(negedge clk);
      instrValid = 1'b0;
      repeat (3) @(negedge clk);
      // Every taken word must have been answered
      `CHK(q.size(), 0)
      close_out;
   end
endmodule // tb_clear_and_decrement_skip_exec
